// file: inc/cps_pkg.sv
// shared constants and types for the card performance and task status block
package cps_pkg;
   localparam int TASK_W = 32;
   localparam int MAX_DEPTH = 32;
   localparam int CQ_CODE_W = 5;
   localparam int STAT_W = 32;
   localparam int TASK_SEL_BIT = 15;
   // enhancement byte positions, relative to status block bit 328
   localparam int ENH_LSB = 328;
   localparam int ENH_CQ_LSB = 3;
   localparam int ENH_CACHE_BIT = 2;
   localparam int ENH_HOST_MAINT_BIT = 1;
   localparam int ENH_CARD_MAINT_BIT = 0;
   localparam logic [4:0] CQ_NONE = 5'h00;
   localparam logic [4:0] CQ_MAX_CODE = 5'h1F;
   localparam logic [7:0] ENH_RST = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [3:0] ALLOC_UNIT_SIZE_FIELD_DEF = 4'h9;

   typedef enum logic [1:0] {
      CPS_OP_ERASE = 2'b00,
      CPS_OP_DISCARD = 2'b01,
      CPS_OP_FULL_ERASE = 2'b10
   } cps_op_t;

   typedef enum logic [0:0] {
      CPS_IDLE = 1'b0,
      CPS_ANSWER = 1'b1
   } cps_state_t;

   typedef struct packed {
      logic [7:0] speed_class;
      logic [7:0] move_perf;
      logic [3:0] alloc_unit_size_field;
      logic [3:0] fast_bus_grade_field;
      logic [3:0] fast_bus_alloc_size_field;
      logic [7:0] video_class;
      logic [9:0] video_alloc_size_field;
      logic [21:0] suspension_location_field;
      logic [3:0] application_class_code;
   } cps_perf_t;

   typedef struct packed {
      logic [15:0] size;
      logic [5:0] timeout;
      logic [1:0] offset;
   } cps_erase_t;

   typedef struct packed {
      logic full_erase_capability_flag;
      logic discard_flag;
   } cps_erase_caps_t;
endpackage

// file: rtl/cps_card_status.sv
// card side status: enhancement byte, area gating of status fields, queued-task ready word
`timescale 1ns/1ps

// How it works
// [R1] an eight-bit enhancement capability byte is reported in the status block
// [R2] status bits 335..331 carry the command-queue capability code
// [R3] bits 330, 329, 328 flag cache, host maintenance, card maintenance; one means supported
// [R4] queue code zero means no queue; code n means depth n+1, up to 1Fh
// [R5] performance and enhancement identifiers are reported as zero in boot or locked user area
// [R6] erase refused and erase fields zeroed in boot or locked user area
// [R7] discard and full erase refused in boot or locked user area
// [R8] performance figures come in as measured with security disabled
// [R9] status command with argument bit 15 set answers with the task word
// [R10] task word bit n is one while queued task n is ready
// [R11] task word bits beyond the queue depth always read zero
// [R12] host sizes recording units in 16 KB multiples inside one allocation unit
// [R13] host derives recording units per allocation unit by division
// [R14] allocation unit size field is one fixed value per card
// [R15] class one hosts treat any nonzero application class code as class one
// [R16] a ready bit clears when its task is executed or discarded
module cps_card_status
   import cps_pkg::*;
#(
   parameter int QUEUE_DEPTH = MAX_DEPTH,
   parameter logic [3:0] ALLOC_UNIT_SIZE_FIELD_CODE = ALLOC_UNIT_SIZE_FIELD_DEF
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // capability settings
   input wire logic i_cache_sup,
   input wire logic i_host_maint_sup,
   input wire logic i_card_maint_sup,
   input wire cps_erase_caps_t i_erase_caps,
   // access context
   input wire logic i_area_boot,
   input wire logic i_area_user_locked,
   // raw status fields
   input wire cps_perf_t i_perf,
   input wire cps_erase_t i_erase,
   // status command
   input wire logic i_stat_cmd_vld,
   input wire logic [STAT_W-1:0] i_stat_arg,
   input wire logic [STAT_W-1:0] i_card_status,
   // queued task events
   input wire logic [TASK_W-1:0] i_task_ready_set,
   input wire logic [TASK_W-1:0] i_task_done_clr,
   // erase class operations
   input wire logic i_op_req,
   input wire cps_op_t i_op_kind,
   // reported fields
   output logic [7:0] o_enhancement_capability_byte,
   output cps_perf_t o_perf,
   output cps_erase_t o_erase,
   output cps_erase_caps_t o_erase_caps,
   output logic [TASK_W-1:0] o_queued_task_ready_word,
   // short response
   output logic o_resp_vld,
   output logic [STAT_W-1:0] o_resp_word,
   // operation outcome
   output logic o_op_grant,
   output logic o_op_refuse
);

   // ----------------------------------------
   // constants derived from the queue depth
   // ----------------------------------------
   localparam logic [CQ_CODE_W-1:0] CQ_CODE = (QUEUE_DEPTH > 1) ?
      CQ_CODE_W'(QUEUE_DEPTH - 1) : CQ_NONE; // [R4]
   localparam int USED_TASKS = (QUEUE_DEPTH > 1) ? QUEUE_DEPTH : 0;

   typedef struct packed {
      cps_state_t state;
      logic [7:0] enh;
      cps_perf_t perf;
      cps_erase_t erase;
      cps_erase_caps_t caps;
      logic [TASK_W-1:0] ready;
      logic [STAT_W-1:0] resp_word;
      logic grant;
      logic refuse;
   } cps_regs_t;

   cps_regs_t state_ff;
   cps_regs_t nxt_state;
   logic locked;
   logic [TASK_W-1:0] task_mask;

   // ----------------------------------------
   // valid task slots
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < TASK_W; gi++) begin : g_mask
         assign task_mask[gi] = (gi < USED_TASKS); // [R11]
      end
   endgenerate

   assign locked = i_area_boot | i_area_user_locked;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_state.grant = 1'b0;
      nxt_state.refuse = 1'b0;

      // capability byte; the whole byte is withheld in a locked area
      nxt_state.enh = ENH_RST;
      if (!locked) begin
         nxt_state.enh[ENH_CQ_LSB +: CQ_CODE_W] = CQ_CODE; // [R1] [R2] [R4]
         nxt_state.enh[ENH_CACHE_BIT] = i_cache_sup; // [R3]
         nxt_state.enh[ENH_HOST_MAINT_BIT] = i_host_maint_sup; // [R3]
         nxt_state.enh[ENH_CARD_MAINT_BIT] = i_card_maint_sup; // [R3]
      end

      // performance figures other than the allocation unit size field are passed as given outside a locked area;
      // with security present they may be the figures measured with security disabled
      nxt_state.perf = i_perf; // [R8]
      nxt_state.perf.alloc_unit_size_field = ALLOC_UNIT_SIZE_FIELD_CODE; // [R14]
      if (locked) begin
         nxt_state.perf = '0; // [R5]
      end

      nxt_state.erase = locked ? '0 : i_erase; // [R6]
      nxt_state.caps = locked ? '0 : i_erase_caps; // [R7]

      // set wins over clear so an event arriving with the clear is kept
      nxt_state.ready = ((state_ff.ready & ~i_task_done_clr) | i_task_ready_set) & task_mask; // [R10] [R16] [R11]

      if (i_op_req) begin
         if (locked) begin
            nxt_state.refuse = 1'b1; // [R6] [R7]
         end else begin
            case (i_op_kind)
               CPS_OP_ERASE: begin
                  nxt_state.grant = 1'b1;
               end
               CPS_OP_DISCARD: begin
                  nxt_state.grant = i_erase_caps.discard_flag;
                  nxt_state.refuse = ~i_erase_caps.discard_flag;
               end
               CPS_OP_FULL_ERASE: begin
                  nxt_state.grant = i_erase_caps.full_erase_capability_flag;
                  nxt_state.refuse = ~i_erase_caps.full_erase_capability_flag;
               end
               default: begin
                  nxt_state.refuse = 1'b1;
               end
            endcase
         end
      end

      case (state_ff.state)
         CPS_IDLE: begin
            if (i_stat_cmd_vld) begin
               nxt_state.state = CPS_ANSWER;
               // the word answers with the ready state as of the command's cycle
               nxt_state.resp_word = i_stat_arg[TASK_SEL_BIT] ? (state_ff.ready & task_mask) : i_card_status; // [R9]
            end
         end
         CPS_ANSWER: begin
            nxt_state.state = CPS_IDLE;
         end
         default: begin
            nxt_state.state = CPS_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_ff <= '{state: CPS_IDLE, enh: ENH_RST, perf: '0, erase: '0, caps: '0,
                       ready: WORD_ZERO, resp_word: WORD_ZERO, grant: 1'b0, refuse: 1'b0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_enhancement_capability_byte = state_ff.enh;
   assign o_perf = state_ff.perf;
   assign o_erase = state_ff.erase;
   assign o_erase_caps = state_ff.caps;
   assign o_queued_task_ready_word = state_ff.ready;
   assign o_resp_vld = (state_ff.state == CPS_ANSWER);
   assign o_resp_word = state_ff.resp_word;
   assign o_op_grant = state_ff.grant;
   assign o_op_refuse = state_ff.refuse;

endmodule

// file: tb/cps_chk_assertions.sv
// port-level checks for the card status block
`timescale 1ns/1ps
module cps_chk
   import cps_pkg::*;
#(parameter int QUEUE_DEPTH = MAX_DEPTH) (
   // clock, reset and inputs
   input wire logic i_clk, i_sys_rst, i_cache_sup, i_host_maint_sup, i_card_maint_sup,
   input wire logic i_area_boot, i_area_user_locked, i_stat_cmd_vld, i_op_req,
   input wire logic [STAT_W-1:0] i_stat_arg,
   input wire logic [TASK_W-1:0] i_task_ready_set, i_task_done_clr,
   // outputs
   input wire logic o_resp_vld, o_op_grant, o_op_refuse,
   input wire logic [STAT_W-1:0] o_resp_word,
   input wire logic [TASK_W-1:0] o_queued_task_ready_word,
   input wire logic [7:0] o_enhancement_capability_byte
);
   localparam logic [4:0] CQ = (QUEUE_DEPTH > 1) ? 5'(QUEUE_DEPTH - 1) : CQ_NONE;
   localparam logic [63:0] UM = (QUEUE_DEPTH > 1) ? (64'h1 << QUEUE_DEPTH) - 64'h1 : 64'h0;
   wire logic lk = i_area_boot | i_area_user_locked;
   wire logic tk = i_stat_cmd_vld & ~o_resp_vld;
   wire logic [TASK_W-1:0] qw = o_queued_task_ready_word;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   a_resp_follows: assert property (tk |=> o_resp_vld) else $error("command not answered");
   a_resp_pulse: assert property (o_resp_vld |=> !o_resp_vld) else $error("response too long");
   a_task_word: assert property (tk && i_stat_arg[TASK_SEL_BIT] |=> o_resp_word == $past(qw))
      else $error("task word wrong");
   a_ready_set: assert property (QUEUE_DEPTH > 1 && i_task_ready_set[0] |=> qw[0])
      else $error("ready bit not set");
   a_ready_clr: assert property (i_task_done_clr[0] && !i_task_ready_set[0] |=> !qw[0])
      else $error("ready bit kept");
   a_unused_zero: assert property ((qw & ~UM[TASK_W-1:0]) == '0) else $error("unused bit set");
   a_op_answer: assert property (i_op_req |=> o_op_grant ^ o_op_refuse) else $error("bad answer");
   a_lock_refuse: assert property (i_op_req && lk |=> o_op_refuse) else $error("locked op granted");
   a_enh_byte: assert property (1'b1 |=> o_enhancement_capability_byte == ($past(lk) ? ENH_RST :
      {CQ, $past(i_cache_sup), $past(i_host_maint_sup), $past(i_card_maint_sup)})) else $error("enh byte wrong");
endmodule
bind cps_card_status cps_chk #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_chk (.*);

// file: tb/cps_host_model.sv
// host side model: issues status commands and reads the short response
`timescale 1ns/1ps
module cps_host_model
   import cps_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resp_vld,
   input wire logic [STAT_W-1:0] i_resp_word,
   input wire logic [3:0] i_app_class,
   output logic o_cmd_vld = 1'b0,
   output logic [STAT_W-1:0] o_arg = 32'h0,
   output logic o_class_one
);
   // recording unit is a whole number of 16 KB blocks and divides the allocation unit evenly
   localparam int RU_KB = 4 * 16;
   localparam int AU_KB = 4096;
   localparam int RUS_PER_AU = AU_KB / RU_KB;
   // higher codes may appear later, so any nonzero code still counts
   assign o_class_one = (i_app_class != 4'h0);
   // a quiet cycle follows each call, so the card is never asked while answering
   task automatic status(input logic sel, output logic vld, output logic [STAT_W-1:0] word);
      @(negedge i_clk);
      o_cmd_vld = 1'b1;
      o_arg = {16'hA5A5, sel, 15'h1234};
      @(negedge i_clk);
      o_cmd_vld = 1'b0;
      o_arg = ~o_arg;
      vld = i_resp_vld;
      word = i_resp_word;
   endtask
endmodule

// file: tb/tb_card_perf_and_task_status.sv
// self-checking bench for the card status block
`timescale 1ns/1ps
module tb_card_perf_and_task_status
   import cps_pkg::*;
;
   localparam int D = 8;
   logic clk = 1'b0, rst = 1'b1, ca = 1'b1, hm = 1'b0, cm = 1'b0, bt = 1'b0, lu = 1'b0, oq = 1'b0;
   logic cv, rv, gr, rf, c1, hv;
   logic [1:0] kd = 2'h0;
   logic [7:0] enh;
   logic [31:0] arg, rw, qw, w, rs = '0, rc = '0, cs = 32'h0000_0900;
   cps_erase_caps_t caps = '0, oc;
   cps_perf_t pf = 72'h11_2233_4455_6677_8892, op;
   cps_erase_t er = 24'h12_3456, oe;
   int checks = 0, n_mismatch = 0;
   // {boot, user locked, full cap, discard cap, kind, grant expected}
   logic [6:0] rows [9] = '{7'h01, 7'h02, 7'h0B, 7'h04, 7'h15, 7'h1E, 7'h58, 7'h3A, 7'h3C};
   always #12.5 clk = ~clk;
   cps_card_status #(.QUEUE_DEPTH(D)) DUT (.i_clk(clk), .i_sys_rst(rst), .i_cache_sup(ca),
      .i_host_maint_sup(hm), .i_card_maint_sup(cm), .i_erase_caps(caps), .i_area_boot(bt),
      .i_area_user_locked(lu), .i_perf(pf), .i_erase(er), .i_stat_cmd_vld(cv), .i_stat_arg(arg),
      .i_card_status(cs), .i_task_ready_set(rs), .i_task_done_clr(rc), .i_op_req(oq),
      .i_op_kind(cps_op_t'(kd)), .o_enhancement_capability_byte(enh), .o_perf(op), .o_erase(oe),
      .o_erase_caps(oc), .o_queued_task_ready_word(qw), .o_resp_vld(rv), .o_resp_word(rw),
      .o_op_grant(gr), .o_op_refuse(rf));
   cps_host_model u_host (.i_clk(clk), .i_resp_vld(rv), .i_resp_word(rw),
      .i_app_class(op.application_class_code), .o_cmd_vld(cv), .o_arg(arg), .o_class_one(c1));
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      chk({enh, qw, rv}, 41'h0);
      rst = 1'b0;
      // requests go back to back, each answer checked in the next cycle
      for (int i = 0; i <= 9; i++) begin
         @(negedge clk);
         if (i > 0) begin
            chk({gr, rf}, {rows[i-1][0], !rows[i-1][0]});
         end
         if (i < 9) {bt, lu, caps, kd} = rows[i][6:1];
         oq = (i < 9);
      end
      @(negedge clk);
      chk({enh, op, oe, oc}, 106'h0);
      {bt, lu} = 2'b00;
      for (int k = 0; k < 8; k++) begin
         {ca, hm, cm} = 3'(k);
         @(negedge clk);
         chk(enh, {5'(D - 1), 3'(k)});
      end
      chk({op.alloc_unit_size_field, c1, oc}, {ALLOC_UNIT_SIZE_FIELD_DEF, 1'b1, 2'b11});
      chk({op.speed_class, op.video_class, op.application_class_code, oe}, {pf.speed_class, pf.video_class, 4'h2, er});
      chk(u_host.RUS_PER_AU, 32'h40);
      rs = 32'hFFFF_FF05;
      @(negedge clk);
      rs = '0;
      u_host.status(1'b1, hv, w);
      chk({hv, w}, {1'b1, 32'h5});
      {rs, rc} = {32'h4, 32'h5};
      @(negedge clk);
      {rs, rc} = '0;
      u_host.status(1'b1, hv, w);
      chk(w, 32'h4);
      u_host.status(1'b0, hv, w);
      chk(w, 32'h0000_0900);
      rst = 1'b1;
      @(negedge clk);
      chk(qw, 32'h0);
      results();
   end
endmodule
